// ### common/rssx_pkg.sv
// Shared constants, types and decode helpers for the rotate/subtract/sleep execution block
package rssx_pkg;

    // Bus geometry
    localparam int unsigned ADDR_W     = 12;
    localparam int unsigned DATA_W     = 32;
    localparam int unsigned FILE_DEPTH = 128;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] EXEC_OFS  = 12'h000;
    localparam logic [ADDR_W-1:0] ACC_OFS   = 12'h004;
    localparam logic [ADDR_W-1:0] STAT_OFS  = 12'h008;
    localparam logic [ADDR_W-1:0] WDOG_OFS  = 12'h00C;
    localparam logic [ADDR_W-1:0] FILE_BASE = 12'h100;
    localparam logic [ADDR_W-1:0] FILE_LAST = 12'h2FC;

    // Command word field positions
    localparam int unsigned EXEC_OP_LSB   = 12;
    localparam int unsigned EXEC_DEST_BIT = 8;

    // Status word field positions
    localparam int unsigned STAT_C   = 0;
    localparam int unsigned STAT_DC  = 1;
    localparam int unsigned STAT_Z   = 2;
    localparam int unsigned STAT_TO  = 3;
    localparam int unsigned STAT_PD  = 4;
    localparam int unsigned STAT_SLP = 5;

    // Reset values
    localparam logic [7:0] ACC_RST  = 8'h00;
    localparam logic       PD_RST   = 1'b1;
    localparam logic       TO_RST   = 1'b1;
    localparam logic [7:0] WDOG_RST = 8'h00;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Operations carried by the command word
    typedef enum logic [1:0] {
        rotate_left_through_carry_op,
        rotate_right_through_carry_op,
        literal_minus_accumulator_op,
        enter_sleep_op
    } rssx_op_t;

    // Decoded command
    typedef struct packed {
        rssx_op_t   op;
        logic       dest;
        logic [7:0] operand;
    } rssx_cmd_t;

    // Datapath result with flags
    typedef struct packed {
        logic [7:0] result;
        logic       carry;
        logic       half_carry;
        logic       zero;
    } rssx_alu_t;

    // Address decode classes
    typedef enum logic [2:0] {
        dec_exec, dec_acc, dec_stat, dec_wdog, dec_file, dec_none
    } rssx_dec_t;

    // Map a byte address to its register class
    function automatic rssx_dec_t rssx_decode(input logic [ADDR_W-1:0] a);
        rssx_dec_t d;
        d = dec_none;
        if (a[1:0] == 2'h0) begin
            if (a == EXEC_OFS) d = dec_exec;
            else if (a == ACC_OFS) d = dec_acc;
            else if (a == STAT_OFS) d = dec_stat;
            else if (a == WDOG_OFS) d = dec_wdog;
            else if (a >= FILE_BASE && a <= FILE_LAST) d = dec_file;
        end
        return d;
    endfunction

    // File location addressed by a byte address in the file window
    function automatic logic [6:0] rssx_file_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] off;
        off = a - FILE_BASE;
        return off[8:2];
    endfunction

endpackage

// ### rtl/rssx_alu.sv
// Combinational rotate-through-carry and literal-minus-accumulator datapath
`timescale 1ns/1ps
module rssx_alu
    import rssx_pkg::*;
(
    // Operation and operands
    input  wire logic [1:0] op,
    input  wire logic [7:0] fval,
    input  wire logic [7:0] acc,
    input  wire logic [7:0] lit,
    // Incoming flags
    input  wire logic       carry_in,
    input  wire logic       half_in,
    input  wire logic       zero_in,
    // Result
    output rssx_alu_t       res
);
    logic [8:0] diff;

    // Result and flag selection; rotates leave half-carry and zero alone
    always_comb begin
        diff = {1'b0, lit} - {1'b0, acc};
        res  = '{result: fval, carry: carry_in, half_carry: half_in, zero: zero_in};
        case (rssx_op_t'(op))
            rotate_left_through_carry_op: begin
                res.result = {fval[6:0], carry_in};
                res.carry  = fval[7];
            end
            rotate_right_through_carry_op: begin
                res.result = {carry_in, fval[7:1]};
                res.carry  = fval[0];
            end
            literal_minus_accumulator_op: begin
                res.result     = diff[7:0];
                res.carry      = ~diff[8];
                res.half_carry = (acc[3:0] <= lit[3:0]);
                res.zero       = (diff[7:0] == 8'h00);
            end
            default: begin
                res.result = fval;
            end
        endcase
    end
endmodule

// ### rtl/rssx_axil.sv
// AXI4-Lite slave front end: one write and one read in flight, strobes to the core
`timescale 1ns/1ps
module rssx_axil
    import rssx_pkg::*;
(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // Write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // Write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // Read address and data
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Core side
    output logic                   wr_fire,
    output logic [ADDR_W-1:0]      wr_addr,
    output logic [DATA_W-1:0]      wr_data,
    output logic [3:0]             wr_strb,
    input  wire logic              wr_err,
    output logic                   rd_fire,
    output logic [ADDR_W-1:0]      rd_addr,
    input  wire logic [DATA_W-1:0] rd_data,
    input  wire logic              rd_err
);
    logic aw_held;
    logic w_held;
    logic ar_held;

    // A write fires once both halves are held, a read once its address is held, each only while no answer is pending
    assign wr_fire = aw_held && w_held && !bvalid;
    assign rd_fire = ar_held && !rvalid;

    // Write address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            awready <= 1'b0;
            wr_addr <= '0;
        end else if (awvalid && awready) begin
            aw_held <= 1'b1;
            awready <= 1'b0;
            wr_addr <= awaddr;
        end else if (wr_fire) begin
            aw_held <= 1'b0;
        end else if (!aw_held && !bvalid) begin
            awready <= 1'b1;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held  <= 1'b0;
            wready  <= 1'b0;
            wr_data <= '0;
            wr_strb <= 4'h0;
        end else if (wvalid && wready) begin
            w_held  <= 1'b1;
            wready  <= 1'b0;
            wr_data <= wdata;
            wr_strb <= wstrb;
        end else if (wr_fire) begin
            w_held <= 1'b0;
        end else if (!w_held && !bvalid) begin
            wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid <= 1'b1;
            bresp  <= wr_err ? RESP_SLVERR : RESP_OKAY;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end

    // Read address capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_held <= 1'b0;
            arready <= 1'b0;
            rd_addr <= '0;
        end else if (arvalid && arready) begin
            ar_held <= 1'b1;
            arready <= 1'b0;
            rd_addr <= araddr;
        end else if (rd_fire) begin
            ar_held <= 1'b0;
        end else if (!ar_held && !rvalid) begin
            arready <= 1'b1;
        end
    end

    // Read data and response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= '0;
            rresp  <= RESP_OKAY;
        end else if (rd_fire) begin
            rvalid <= 1'b1;
            rdata  <= rd_data;
            rresp  <= rd_err ? RESP_SLVERR : RESP_OKAY;
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
        end
    end
endmodule

// ### rtl/rssx_exec.sv
// Execution block for rotate-through-carry, literal subtract and low-power entry
//
// Design decisions made here: the register offsets and the AXI4-Lite register port.
`timescale 1ns/1ps
module rssx_exec
    import rssx_pkg::*;
#(
    parameter int unsigned PRE_W = 8
)(
    // Clock and reset
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite write address and data
    input  wire logic [ADDR_W-1:0] awaddr,
    input  wire logic              awvalid,
    output logic                   awready,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic [3:0]        wstrb,
    input  wire logic              wvalid,
    output logic                   wready,
    // AXI4-Lite write response
    output logic [1:0]             bresp,
    output logic                   bvalid,
    input  wire logic              bready,
    // AXI4-Lite read
    input  wire logic [ADDR_W-1:0] araddr,
    input  wire logic              arvalid,
    output logic                   arready,
    output logic [DATA_W-1:0]      rdata,
    output logic [1:0]             rresp,
    output logic                   rvalid,
    input  wire logic              rready,
    // Low-power control
    input  wire logic              wake_pin,
    output logic                   osc_stop,
    output logic                   wdog_clear
);
    // Parameter check
    if (PRE_W < 1 || PRE_W > 16) begin : g_bad_pre
        $error("PRE_W must lie between 1 and 16");
    end

    logic              wr_fire;
    logic [ADDR_W-1:0] wr_addr;
    logic [DATA_W-1:0] wr_data;
    logic [3:0]        wr_strb;
    logic              wr_err;
    logic              rd_fire;
    logic [ADDR_W-1:0] rd_addr;
    logic [DATA_W-1:0] rd_data;
    logic              rd_err;
    rssx_dec_t         wr_dec;
    rssx_dec_t         rd_dec;

    logic [7:0]        acc;
    logic              carry;
    logic              half_carry;
    logic              zero;
    logic              power_down_flag;
    logic              timeout_flag;
    logic [PRE_W-1:0]  prescaler;
    logic [7:0]        watchdog_counter;
    logic [7:0]        file_mem [FILE_DEPTH];
    logic              wake_s1;
    logic              wake_s2;
    logic              wake_s3;
    logic              wake_now;

    rssx_cmd_t         cmd;
    logic [6:0]        fidx;
    logic [7:0]        fval;
    logic [7:0]        lit;
    rssx_alu_t         alu_o;
    logic [7:0]        alu_res;
    logic              exec_fire;
    logic              rot_fire;
    logic              sub_fire;
    logic              sleep_fire;

    // Bus slave
    rssx_axil u_axil (
        .aclk    (aclk),
        .aresetn (aresetn),
        .awaddr  (awaddr),
        .awvalid (awvalid),
        .awready (awready),
        .wdata   (wdata),
        .wstrb   (wstrb),
        .wvalid  (wvalid),
        .wready  (wready),
        .bresp   (bresp),
        .bvalid  (bvalid),
        .bready  (bready),
        .araddr  (araddr),
        .arvalid (arvalid),
        .arready (arready),
        .rdata   (rdata),
        .rresp   (rresp),
        .rvalid  (rvalid),
        .rready  (rready),
        .wr_fire (wr_fire),
        .wr_addr (wr_addr),
        .wr_data (wr_data),
        .wr_strb (wr_strb),
        .wr_err  (wr_err),
        .rd_fire (rd_fire),
        .rd_addr (rd_addr),
        .rd_data (rd_data),
        .rd_err  (rd_err)
    );

    // Command decode from the held write word
    assign wr_dec = rssx_decode(wr_addr);
    assign rd_dec = rssx_decode(rd_addr);
    assign cmd    = '{op: rssx_op_t'(wr_data[EXEC_OP_LSB +: 2]),
                      dest: wr_data[EXEC_DEST_BIT],
                      operand: wr_data[7:0]};
    assign fidx   = cmd.operand[6:0];
    assign fval   = file_mem[fidx];
    assign lit    = cmd.operand;

    // Commands run only while awake and with both low byte lanes written
    assign exec_fire  = wr_fire && (wr_dec == dec_exec) && (wr_strb[1:0] == 2'h3)
                        && !osc_stop;
    assign rot_fire   = exec_fire && (cmd.op == rotate_left_through_carry_op
                        || cmd.op == rotate_right_through_carry_op);
    assign sub_fire   = exec_fire && (cmd.op == literal_minus_accumulator_op);
    assign sleep_fire = exec_fire && (cmd.op == enter_sleep_op);
    assign wr_err     = (wr_dec == dec_none) || ((wr_dec == dec_exec) && osc_stop);

    // Datapath
    rssx_alu u_alu (
        .op       (cmd.op),
        .fval     (fval),
        .acc      (acc),
        .lit      (lit),
        .carry_in (carry),
        .half_in  (half_carry),
        .zero_in  (zero),
        .res      (alu_o)
    );
    assign alu_res = alu_o.result;

    // Accumulator
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acc <= ACC_RST;
        end else if ((rot_fire && !cmd.dest) || sub_fire) begin
            acc <= alu_o.result;
        end else if (wr_fire && wr_dec == dec_acc && wr_strb[0]) begin
            acc <= wr_data[7:0];
        end
    end

    // Arithmetic flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            carry      <= 1'b0;
            half_carry <= 1'b0;
            zero       <= 1'b0;
        end else if (rot_fire || sub_fire) begin
            carry      <= alu_o.carry;
            half_carry <= alu_o.half_carry;
            zero       <= alu_o.zero;
        end else if (wr_fire && wr_dec == dec_stat && wr_strb[0]) begin
            carry      <= wr_data[STAT_C];
            half_carry <= wr_data[STAT_DC];
            zero       <= wr_data[STAT_Z];
        end
    end

    // File registers, written back by rotates or by the bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < FILE_DEPTH; i++) begin
                file_mem[i] <= 8'h00;
            end
        end else if (rot_fire && cmd.dest) begin
            file_mem[fidx] <= alu_o.result;
        end else if (wr_fire && wr_dec == dec_file && wr_strb[0]) begin
            file_mem[rssx_file_index(wr_addr)] <= wr_data[7:0];
        end
    end

    // Wake pin synchroniser; level counts once stages two and three agree
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wake_s1 <= 1'b0;
            wake_s2 <= 1'b0;
            wake_s3 <= 1'b0;
        end else begin
            wake_s1 <= wake_pin;
            wake_s2 <= wake_s1;
            wake_s3 <= wake_s2;
        end
    end
    assign wake_now = wake_s2 && wake_s3;

    // Power status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            power_down_flag <= PD_RST;
            timeout_flag    <= TO_RST;
        end else if (sleep_fire) begin
            power_down_flag <= 1'b0;
            timeout_flag    <= 1'b1;
        end
    end

    // Sleep state; entry wins over a wake seen in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            osc_stop <= 1'b0;
        end else if (sleep_fire) begin
            osc_stop <= 1'b1;
        end else if (wake_now) begin
            osc_stop <= 1'b0;
        end
    end

    // Watchdog prescaler and counter, cleared on sleep entry
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            prescaler        <= '0;
            watchdog_counter <= WDOG_RST;
            wdog_clear       <= 1'b0;
        end else begin
            wdog_clear <= sleep_fire;
            if (sleep_fire) begin
                prescaler        <= '0;
                watchdog_counter <= WDOG_RST;
            end else begin
                prescaler <= prescaler + 1'b1;
                if (&prescaler) begin
                    watchdog_counter <= watchdog_counter + 8'h01;
                end
            end
        end
    end

    // Read data selection
    always_comb begin
        rd_data = '0;
        rd_err  = 1'b0;
        case (rd_dec)
            dec_exec: rd_data = '0;
            dec_acc:  rd_data[7:0] = acc;
            dec_stat: begin
                rd_data[STAT_C]   = carry;
                rd_data[STAT_DC]  = half_carry;
                rd_data[STAT_Z]   = zero;
                rd_data[STAT_TO]  = timeout_flag;
                rd_data[STAT_PD]  = power_down_flag;
                rd_data[STAT_SLP] = osc_stop;
            end
            dec_wdog: begin
                rd_data[7:0]  = watchdog_counter;
                rd_data[23:8] = 16'(prescaler);
            end
            dec_file: rd_data[7:0] = file_mem[rssx_file_index(rd_addr)];
            default:  rd_err = 1'b1;
        endcase
    end

    // Reference values for checking
    logic [8:0] ref_left;
    logic [8:0] ref_right;
    assign ref_left  = {fval[7], fval[6:0], carry};
    assign ref_right = {fval[0], carry, fval[7:1]};

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_sleep_issue;
        exec_fire && cmd.op == enter_sleep_op;
    endsequence

    sequence s_asleep;
        osc_stop && !power_down_flag;
    endsequence

    a_rotl_to_acc: assert property (
        exec_fire && cmd.op == rotate_left_through_carry_op && !cmd.dest
        |=> {carry, acc} == $past(ref_left))
        else $error("left rotate result or carry wrong");

    a_dest_file: assert property (
        rot_fire && cmd.dest
        |=> $stable(acc) && file_mem[$past(fidx)] == $past(alu_res))
        else $error("rotate with file destination wrong");

    a_dest_acc: assert property (
        rot_fire && !cmd.dest |=> file_mem[$past(fidx)] == $past(fval))
        else $error("rotate to accumulator disturbed the file register");

    a_rotr_to_acc: assert property (
        exec_fire && cmd.op == rotate_right_through_carry_op && !cmd.dest
        |=> {carry, acc} == $past(ref_right))
        else $error("right rotate result or carry wrong");

    a_sleep_flags: assert property (
        s_sleep_issue |=> !power_down_flag && timeout_flag)
        else $error("power flags wrong after sleep entry");

    a_sleep_wdog: assert property (
        s_sleep_issue |=> watchdog_counter == 8'h00 && prescaler == '0 && wdog_clear)
        else $error("watchdog not cleared on sleep entry");

    a_sleep_halt: assert property (
        s_sleep_issue ##1 s_asleep ##0 !wake_now |=> s_asleep)
        else $error("sleep left without a wake");

    a_sleep_enter: assert property (
        s_sleep_issue |=> s_asleep)
        else $error("oscillator not stopped after sleep entry");

    a_halt_hold: assert property (
        osc_stop && wr_fire && wr_dec == dec_exec
        |=> $stable(acc) && $stable(carry) && bresp == RESP_SLVERR)
        else $error("command ran while asleep");

    a_sub_result: assert property (
        sub_fire |=> acc == 8'($past(lit) - $past(acc)))
        else $error("literal subtract result wrong");

    a_sub_flags: assert property (
        sub_fire |=> carry == ($past(acc) <= $past(lit))
        && half_carry == (($past(acc) & 8'h0F) <= ($past(lit) & 8'h0F))
        && zero == (acc == 8'h00))
        else $error("literal subtract flags wrong");
endmodule

// ### test/tb.sv
// Self-checking bench for the rotate, subtract and sleep execution block
`timescale 1ns/1ps
module tb;
    import rssx_pkg::*;
    logic              aclk, aresetn;
    logic [ADDR_W-1:0] awaddr, araddr;
    logic              awvalid, wvalid, bready, arvalid, rready, wake_pin;
    logic [DATA_W-1:0] wdata, rdata;
    logic [3:0]        wstrb;
    logic              awready, wready, bvalid, arready, rvalid, osc_stop, wdog_clear;
    logic [1:0]        bresp, rresp, rsp;
    logic [31:0]       rd;
    int                n_mismatch, cmp_count, n_cyc, n_clr;

    // Device under test with a short prescaler
    rssx_exec #(.PRE_W(2)) u_dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
        .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
        .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready), .wake_pin(wake_pin), .osc_stop(osc_stop),
        .wdog_clear(wdog_clear)
    );

    // Clock at 200 MHz
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    // Cycle ceiling and watchdog-clear pulse count
    always @(posedge aclk) begin
        n_cyc <= n_cyc + 1;
        if (wdog_clear === 1'b1) n_clr <= n_clr + 1;
        if (n_cyc == 20000) begin
            n_mismatch = n_mismatch + 1;
            close_out();
        end
    end

    // Compare one value against its expectation
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            n_mismatch = n_mismatch + 1;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Bus write; address and data offered together, response awaited
    task automatic wr(input logic [11:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= 4'hF;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid) begin
                r = bresp;
                bready <= 1'b0;
                break;
            end
        end
    endtask

    // Bus read; data and response taken at the rvalid edge
    task automatic rdx(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        forever begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid) begin
                d = rdata;
                r = rresp;
                rready <= 1'b0;
                break;
            end
        end
    endtask

    // Command word: operation, destination, operand
    function automatic logic [31:0] cmd(input logic [1:0] op, input logic d, input logic [7:0] v);
        return {18'h0, op, 3'h0, d, v};
    endfunction

    // Verdict
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    logic [7:0] acc_t [4] = '{8'h05, 8'h03, 8'h1F, 8'h00};
    logic [7:0] lit_t [4] = '{8'h03, 8'h03, 8'h20, 8'hFF};
    logic [7:0] ex;

    initial begin
        {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
        {wake_pin, wstrb, n_mismatch, cmp_count, n_cyc, n_clr} = '0;
        aresetn = 1'b0;
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);

        // Reset state of status and accumulator
        rdx(STAT_OFS, rd, rsp); chk(rd, 32'h18);
        rdx(ACC_OFS, rd, rsp); chk(rd, 32'h0);
        rdx(12'h010, rd, rsp); chk(rd, 32'h0);
        chk({30'h0, rsp}, {30'h0, RESP_SLVERR});
        $display("Reset and map test done");

        // Left rotate of the top file location into the accumulator
        wr(FILE_BASE + 12'h1FC, 32'hE6, rsp);
        wr(EXEC_OFS, cmd(2'h0, 1'b0, 8'h7F), rsp); chk(rsp, RESP_OKAY);
        rdx(ACC_OFS, rd, rsp); chk(rd, 32'hCC);
        rdx(STAT_OFS, rd, rsp); chk(rd[0], 1'b1);
        rdx(FILE_BASE + 12'h1FC, rd, rsp); chk(rd, 32'hE6);
        $display("Left rotate test done");

        // Right rotate written back to the file, carry in from the left rotate
        wr(FILE_BASE + 12'h014, 32'h01, rsp);
        wr(EXEC_OFS, cmd(2'h1, 1'b1, 8'h05), rsp);
        rdx(FILE_BASE + 12'h014, rd, rsp); chk(rd, 32'h80);
        rdx(STAT_OFS, rd, rsp); chk(rd[0], 1'b1);
        rdx(ACC_OFS, rd, rsp); chk(rd, 32'hCC);
        $display("Right rotate test done");

        // Literal minus accumulator over boundary cases
        for (int i = 0; i < 4; i++) begin
            ex = lit_t[i] - acc_t[i];
            wr(ACC_OFS, {24'h0, acc_t[i]}, rsp);
            wr(EXEC_OFS, cmd(2'h2, 1'b0, lit_t[i]), rsp);
            rdx(ACC_OFS, rd, rsp); chk(rd, {24'h0, ex});
            rdx(STAT_OFS, rd, rsp);
            chk(rd[2:0], {ex == 8'h0, acc_t[i][3:0] <= lit_t[i][3:0], acc_t[i] <= lit_t[i]});
        end
        $display("Subtract test done");

        // Sleep entry: flags, watchdog clear, oscillator stop
        wr(EXEC_OFS, cmd(2'h3, 1'b0, 8'h00), rsp);
        chk(osc_stop, 1'b1);
        rdx(STAT_OFS, rd, rsp); chk(rd[5:3], 3'b101);
        chk(n_clr, 1);
        rdx(WDOG_OFS, rd, rsp); chk(rd[7:0] < 8'h03, 1'b1);
        wr(EXEC_OFS, cmd(2'h2, 1'b0, 8'h10), rsp); chk(rsp, RESP_SLVERR);
        rdx(ACC_OFS, rd, rsp); chk(rd, 32'hFF);
        wake_pin <= 1'b1;
        repeat (5) @(posedge aclk);
        chk(osc_stop, 1'b0);
        wake_pin <= 1'b0;
        rdx(STAT_OFS, rd, rsp); chk(rd[5:3], 3'b001);
        wr(EXEC_OFS, cmd(2'h2, 1'b0, 8'h10), rsp); chk(rsp, RESP_OKAY);
        rdx(ACC_OFS, rd, rsp); chk(rd, 32'h11);
        $display("Sleep test done");
        close_out();
    end
endmodule
